// >>> rtl/motion_event_detector_two.sv
// Second programmable motion event generator with its four registers.
module motion_event_detector_two
   import motion_event_two_pkg::*;
#(
   parameter int TICK_FAST_CYCLES = STEP_FAST_CYCLES,
   parameter int TICK_SLOW_CYCLES = STEP_SLOW_CYCLES
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Register port.
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWriteData,
   output logic [7:0]      regReadData_q,
   output logic            regReadValid_q,
   // Measurement side.
   input  wire logic       rateFast,
   input  wire logic [7:0] xSample,
   input  wire logic [7:0] ySample,
   input  wire logic [7:0] zSample,
   // Pad routing.
   input  wire logic       motionEventOne,
   input  wire logic       dataReady,
   input  wire logic [2:0] padOneSelect,
   input  wire logic [2:0] padTwoSelect,
   output logic            padOne_q,
   output logic            padTwo_q,
   output logic            motionEventTwo_q
);

   logic [7:0]            cfg_q;
   logic [7:0]            src_q;
   logic [7:0]            ths_q;
   logic [7:0]            dur_q;
   logic [7:0]            cnt_q;
   logic [TICK_CNT_W-1:0] tickCnt_q;
   logic                  tick_q;
   logic [5:0]            raw;
   logic [5:0]            enables;
   logic [5:0]            hits;
   logic                  combined;
   logic                  fire;
   logic                  latched;
   logic                  held;
   logic                  freeze;
   logic                  readSrc;
   logic                  srcLoad;
   logic [TICK_CNT_W-1:0] tickLast;
   logic [5:0]            expHits;

   // Routes one pad from its select code; unused codes drive low.
   function automatic logic padRoute(input logic [2:0] sel, input logic one,
                                     input logic two, input logic ready);
      unique case (sel)
         PAD_GROUND:     padRoute = 1'b0;
         PAD_EVENT_ONE:  padRoute = one;
         PAD_EVENT_TWO:  padRoute = two;
         PAD_EVENT_ANY:  padRoute = one | two;
         PAD_DATA_READY: padRoute = ready;
         default:        padRoute = 1'b0;
      endcase
   endfunction : padRoute

   // Reference axis decisions for the checks, worked in integers so that they share
   // no gate with the comparators that they watch.
   function automatic logic [5:0] refHits(input logic [7:0] c, input logic [6:0] th,
                                           input logic [7:0] x, input logic [7:0] y,
                                           input logic [7:0] z);
      logic [7:0] s [3];
      logic [5:0] h;
      int         m;
      h = 6'h00;
      s = '{x, y, z};
      for (int a = 0; a < 3; a++) begin
         m = int'($signed(s[a]));
         m = (m < 0) ? -m : m;
         m = (m > 127) ? 127 : m;
         h[2*a+1] = m > int'(th);
         h[2*a]   = m < int'(th);
      end
      refHits = h & c[5:0];
   endfunction : refHits

   // Per-axis comparators, ordered z, y, x so that bits match the flags.
   axis_compare u_cmp_z (
      .sample    (zSample),
      .threshold (ths_q[THRESHOLD_MSB:0]),
      .aboveHigh (raw[5]),
      .belowLow  (raw[4])
   );
   axis_compare u_cmp_y (
      .sample    (ySample),
      .threshold (ths_q[THRESHOLD_MSB:0]),
      .aboveHigh (raw[3]),
      .belowLow  (raw[2])
   );
   axis_compare u_cmp_x (
      .sample    (xSample),
      .threshold (ths_q[THRESHOLD_MSB:0]),
      .aboveHigh (raw[1]),
      .belowLow  (raw[0])
   );

   // Event qualification: enables gate raw conditions, then combine.
   assign enables  = cfg_q[ENABLE_MSB:0];
   assign hits     = raw & enables;
   assign combined = cfg_q[COMBINE_SELECT_BIT]
                     ? ((enables != 6'h00) && (hits == enables))
                     : (hits != 6'h00);
   assign fire     = combined && (cnt_q >= dur_q);
   assign latched  = cfg_q[LATCH_REQUEST_BIT];
   assign held     = latched && src_q[EVENT_ACTIVE_BIT];
   assign freeze   = held && combined;
   assign readSrc  = regRead && (regAddr == SRC_ADDR);
   // A latched source reloads only when empty or being read in this cycle.
   assign srcLoad  = tick_q && (latched ? (fire && (!held || readSrc)) : 1'b1);
   assign tickLast = rateFast ? TICK_CNT_W'(TICK_FAST_CYCLES - 1)
                              : TICK_CNT_W'(TICK_SLOW_CYCLES - 1);

   // Output data rate tick; a rate change keeps the count running, and a count already past the new end ticks at once.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tickCnt_q <= '0;
         tick_q    <= 1'b0;
      end else if (tickCnt_q >= tickLast) begin
         tickCnt_q <= '0;
         tick_q    <= 1'b1;
      end else begin
         tickCnt_q <= tickCnt_q + TICK_CNT_W'(1);
         tick_q    <= 1'b0;
      end
   end

   // Host writable registers; the source register takes no writes.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_q <= CFG_RESET;
         ths_q <= THS_RESET;
         dur_q <= DUR_RESET;
      end else if (regWrite) begin
         if (regAddr == CFG_ADDR) begin
            cfg_q <= regWriteData;
         end
         if (regAddr == THS_ADDR) begin
            ths_q <= regWriteData;
         end
         if (regAddr == DUR_ADDR) begin
            dur_q <= regWriteData;
         end
      end
   end

   // Duration counter, stepped once per data rate tick.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q <= 8'h00;
      end else if (tick_q) begin
         if (freeze) begin
            cnt_q <= cnt_q;
         end else if (combined) begin
            if (cnt_q != 8'hFF) begin
               cnt_q <= cnt_q + 8'h01;
            end
         end else if (ths_q[DECREMENT_MODE_BIT]) begin
            if (cnt_q != 8'h00) begin
               cnt_q <= cnt_q - 8'h01;
            end
         end else begin
            cnt_q <= 8'h00;
         end
      end
   end

   // Source register. A new event in the cycle of a read wins over the clear.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         src_q <= SRC_RESET;
      end else if (srcLoad) begin
         src_q <= {1'b0, fire, fire ? hits : 6'h00};
      end else if (readSrc) begin
         src_q <= 8'h00;
      end
   end

   // The interrupt follows the active flag, so a read drops it too.
   assign motionEventTwo_q = src_q[EVENT_ACTIVE_BIT];

   // Read answer, one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regReadData_q  <= 8'h00;
         regReadValid_q <= 1'b0;
      end else begin
         regReadValid_q <= regRead;
         unique case (regAddr)
            CFG_ADDR: regReadData_q <= cfg_q;
            SRC_ADDR: regReadData_q <= src_q;
            THS_ADDR: regReadData_q <= ths_q;
            DUR_ADDR: regReadData_q <= dur_q;
            default:  regReadData_q <= 8'h00;
         endcase
      end
   end

   // Pads are registered, so they trail the event state by one cycle.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         padOne_q <= 1'b0;
         padTwo_q <= 1'b0;
      end else begin
         padOne_q <= padRoute(padOneSelect, motionEventOne,
                              src_q[EVENT_ACTIVE_BIT], dataReady);
         padTwo_q <= padRoute(padTwoSelect, motionEventOne,
                              src_q[EVENT_ACTIVE_BIT], dataReady);
      end
   end

   // Checks of the block's behaviour against its causes.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Expected enabled hits straight from the samples, for the checks below only.
   assign expHits = refHits(cfg_q, ths_q[THRESHOLD_MSB:0], xSample, ySample, zSample);

   property p_or_combine;
      !cfg_q[COMBINE_SELECT_BIT] |-> combined == (expHits != 6'h00);
   endproperty
   a_or_combine: assert property (p_or_combine)
      else $error("OR combination wrong");

   property p_and_combine;
      cfg_q[COMBINE_SELECT_BIT] |->
         combined == ((enables != 6'h00) && (expHits == enables));
   endproperty
   a_and_combine: assert property (p_and_combine)
      else $error("AND combination wrong");

   property p_enable_gate;
      (hits & 6'h2A) == (expHits & 6'h2A);
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("High axis condition wrong");

   property p_low_gate;
      (hits & 6'h15) == (expHits & 6'h15);
   endproperty
   a_low_gate: assert property (p_low_gate)
      else $error("Low axis condition wrong");

   property p_flags_loaded;
      tick_q && fire && srcLoad |=>
         src_q[EVENT_ACTIVE_BIT] && src_q[FLAG_MSB:0] == $past(hits);
   endproperty
   a_flags_loaded: assert property (p_flags_loaded)
      else $error("Source flags do not match event");

   sequence s_read_quiet;
      readSrc && !srcLoad;
   endsequence
   property p_read_clears;
      s_read_quiet |=> src_q == 8'h00 ##1 (!padTwo_q || $past(padTwoSelect) != PAD_EVENT_TWO);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("Source read did not clear");

   property p_write_ignored;
      regWrite && regAddr == SRC_ADDR && !srcLoad && !readSrc |=> $stable(src_q);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("Source register took a write");

   property p_latched_hold;
      held && latched && !readSrc |=> $stable(src_q);
   endproperty
   a_latched_hold: assert property (p_latched_hold)
      else $error("Latched source changed before read");

   property p_unlatched_drop;
      !latched && tick_q && !fire && !readSrc |=> !motionEventTwo_q;
   endproperty
   a_unlatched_drop: assert property (p_unlatched_drop)
      else $error("Unlatched request was held");

   property p_counter_reset;
      tick_q && !combined && !ths_q[DECREMENT_MODE_BIT] |=> cnt_q == 8'h00;
   endproperty
   a_counter_reset: assert property (p_counter_reset)
      else $error("Counter not reset");

   property p_counter_decrement;
      tick_q && !combined && ths_q[DECREMENT_MODE_BIT] && cnt_q != 8'h00 |=>
         cnt_q == $past(cnt_q) - 8'h01;
   endproperty
   a_counter_decrement: assert property (p_counter_decrement)
      else $error("Counter not decremented");

   property p_counter_freeze;
      tick_q && freeze |=> $stable(cnt_q);
   endproperty
   a_counter_freeze: assert property (p_counter_freeze)
      else $error("Counter moved while frozen");

   property p_tick_lone;
      tick_q |=> !tick_q;
   endproperty
   a_tick_lone: assert property (p_tick_lone)
      else $error("Rate tick lasted two cycles");

   property p_count_step;
      tick_q && combined && !freeze && cnt_q != 8'hFF |=> cnt_q == $past(cnt_q) + 8'h01;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("Counter did not step on a true tick");

   property p_active_flag;
      src_q[EVENT_ACTIVE_BIT] |-> src_q[FLAG_MSB:0] != 6'h00;
   endproperty
   a_active_flag: assert property (p_active_flag)
      else $error("Active flag without cause");

   property p_pad_two;
      padTwoSelect == PAD_EVENT_TWO ##1 padTwoSelect == PAD_EVENT_TWO |->
         padTwo_q == $past(src_q[EVENT_ACTIVE_BIT]);
   endproperty
   a_pad_two: assert property (p_pad_two)
      else $error("Pad two does not follow event two");

endmodule : motion_event_detector_two

// >>> rtl/motion_event_two_pkg.sv
// Package with register map, field positions, reset values and timing constants.
package motion_event_two_pkg;

   // Register offsets on the serial register port.
   localparam logic [7:0] CFG_ADDR = 8'h34;
   localparam logic [7:0] SRC_ADDR = 8'h35;
   localparam logic [7:0] THS_ADDR = 8'h36;
   localparam logic [7:0] DUR_ADDR = 8'h37;

   // Reset values.
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] SRC_RESET = 8'h00;
   localparam logic [7:0] THS_RESET = 8'h00;
   localparam logic [7:0] DUR_RESET = 8'h00;

   // Configuration register fields; enables sit in bits 5..0.
   localparam int COMBINE_SELECT_BIT = 7;
   localparam int LATCH_REQUEST_BIT  = 6;
   localparam int ENABLE_MSB         = 5;

   // Source register fields; the six per-axis flags share the enable layout.
   localparam int EVENT_ACTIVE_BIT = 6;
   localparam int FLAG_MSB         = 5;

   // Threshold register fields.
   localparam int DECREMENT_MODE_BIT = 7;
   localparam int THRESHOLD_MSB      = 6;

   // Interrupt pad routing codes.
   localparam logic [2:0] PAD_GROUND     = 3'h0;
   localparam logic [2:0] PAD_EVENT_ONE  = 3'h1;
   localparam logic [2:0] PAD_EVENT_TWO  = 3'h2;
   localparam logic [2:0] PAD_EVENT_ANY  = 3'h3;
   localparam logic [2:0] PAD_DATA_READY = 3'h4;

   // Duration step per output data rate, in microseconds, and the clock period.
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_FAST_US  = 2500;
   localparam int STEP_SLOW_US  = 10000;
   localparam int STEP_FAST_CYCLES = STEP_FAST_US * 1000 / CLK_PERIOD_NS;
   localparam int STEP_SLOW_CYCLES = STEP_SLOW_US * 1000 / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 20;

endpackage : motion_event_two_pkg

// >>> rtl/axis_compare.sv
// One axis: magnitude of a signed sample compared against the threshold.
module axis_compare
   import motion_event_two_pkg::*;
(
   // Sample and threshold.
   input  wire logic [7:0] sample,
   input  wire logic [6:0] threshold,
   // Raw conditions before enables.
   output logic            aboveHigh,
   output logic            belowLow
);

   // Magnitude of a two's complement sample; -128 saturates to 127.
   function automatic logic [6:0] magnitude(input logic [7:0] s);
      logic [7:0] neg;
      neg = 8'h00 - s;
      if (!s[7]) begin
         magnitude = s[6:0];
      end else if (neg[7]) begin
         magnitude = 7'h7F;
      end else begin
         magnitude = neg[6:0];
      end
   endfunction : magnitude

   // Strict comparisons: a sample equal to the threshold raises neither.
   assign aboveHigh = magnitude(sample) > threshold;
   assign belowLow  = magnitude(sample) < threshold;

endmodule : axis_compare

// >>> testbench/host_port.sv
// Host model that drives the register port of the second event generator.
module host_port (
   // Clock.
   input  wire logic       clk,
   // Register port.
   output logic            regWrite,
   output logic            regRead,
   output logic [7:0]      regAddr,
   output logic [7:0]      regWriteData,
   input  wire logic [7:0] regReadData_q,
   input  wire logic       regReadValid_q
);
   timeunit 1ns;
   timeprecision 1ps;

   // The port is idle at time zero.
   initial begin
      regWrite     = 1'b0;
      regRead      = 1'b0;
      regAddr      = 8'h00;
      regWriteData = 8'h00;
   end

   // One write; data is inverted afterwards so that stale data never looks valid.
   task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite     <= 1'b1;
      regAddr      <= a;
      regWriteData <= d;
      @(posedge clk);
      regWrite     <= 1'b0;
      regWriteData <= ~d;
   endtask : writeReg

   // One read, acknowledging a latched event when aimed at the source register.
   task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      ok = regReadValid_q;
      d  = regReadData_q;
   endtask : readReg
endmodule : host_port

// >>> testbench/testbench.sv
// Self-checking bench for the second motion event generator.
module testbench
   import motion_event_two_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FAST = 8;
   localparam int SLOW = 16;
   localparam int LIMIT = 8000;
   logic       clk, reset_n, regWrite, regRead, regReadValid_q, rateFast, motionEventOne;
   logic       dataReady, padOne_q, padTwo_q, motionEventTwo_q, prevIntr;
   logic [7:0] regAddr, regWriteData, regReadData_q, xSample, ySample, zSample, d, c, e;
   logic [2:0] padOneSelect, padTwoSelect;
   int         errTotal = 0, compares = 0, cyc = 0, lastRise = 0, riseDelta = 0;
   int         rises = 0, seed = 29496, n, t;

   motion_event_detector_two #(.TICK_FAST_CYCLES(FAST), .TICK_SLOW_CYCLES(SLOW))
      motion_event_detector_two_i (.clk(clk), .reset_n(reset_n), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
      .regReadData_q(regReadData_q), .regReadValid_q(regReadValid_q), .rateFast(rateFast),
      .xSample(xSample), .ySample(ySample), .zSample(zSample), .motionEventOne(motionEventOne),
      .dataReady(dataReady), .padOneSelect(padOneSelect), .padTwoSelect(padTwoSelect),
      .padOne_q(padOne_q), .padTwo_q(padTwo_q), .motionEventTwo_q(motionEventTwo_q));
   host_port host_i (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWriteData(regWriteData), .regReadData_q(regReadData_q),
      .regReadValid_q(regReadValid_q));

   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cycle count; a hang is cut short at the ceiling.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errTotal++;
         stop_test();
      end
   end

   // Interrupt rises are timed in cycles, sampled away from the active edge.
   always @(negedge clk) begin
      if (motionEventTwo_q === 1'b1 && !prevIntr) begin
         riseDelta = cyc - lastRise;
         lastRise  = cyc;
         rises++;
      end
      prevIntr = (motionEventTwo_q === 1'b1);
   end

   // Comparison of register-width values and single bits.
   task automatic cmp8(input string nm, input logic [7:0] ex, input logic [7:0] got);
      compares++;
      if (got !== ex) begin
         errTotal++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask : cmp8

   // Comparison of cycle counts.
   task automatic cmpN(input string nm, input int ex, input int got);
      compares++;
      if (got != ex) begin
         errTotal++;
         $display("MISMATCH %s expected %0d seen %0d", nm, ex, got);
      end
   endtask : cmpN

   // Register read whose answer must come with its valid pulse.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      logic ok;
      host_i.readReg(a, v, ok);
      cmp8("valid", 8'h01, {7'h00, ok});
   endtask : rd

   // Waits a bounded time for the next interrupt rise and gives its spacing.
   task automatic waitRise(output int dl);
      int r0;
      r0 = rises;
      repeat (400) if (rises == r0) @(posedge clk);
      cmpN("rise", 1, rises - r0);
      dl = riseDelta;
   endtask : waitRise

   // Disables every condition so the source empties and the counter returns to zero.
   task automatic quiet();
      host_i.writeReg(CFG_ADDR, 8'h00);
      host_i.writeReg(THS_ADDR, 8'h00);
      rd(SRC_ADDR, d);
      repeat (40) @(posedge clk);
   endtask : quiet

   // Source value the rules predict for steady samples once the duration has run out.
   function automatic logic [7:0] expSrc(logic [7:0] cf, logic [6:0] th, logic [7:0] x,
                                         logic [7:0] y, logic [7:0] z);
      logic [7:0] s [3];
      logic [5:0] h;
      int         m;
      s = '{x, y, z};
      for (int a = 0; a < 3; a++) begin
         m = $signed(s[a]);
         m = (m < 0) ? ((m == -128) ? 127 : -m) : m;
         h[2*a+1] = m > int'(th);
         h[2*a]   = m < int'(th);
      end
      h = h & cf[5:0];
      if (cf[7] ? (cf[5:0] != 6'h00 && h == cf[5:0]) : (h != 6'h00)) begin
         return {2'b01, h};
      end
      return 8'h00;
   endfunction : expSrc

   // Pad level predicted from its routing code.
   function automatic logic padExp(logic [2:0] sel, logic one, logic two, logic rdy);
      case (sel)
         3'h1: return one;
         3'h2: return two;
         3'h3: return one | two;
         3'h4: return rdy;
         default: return 1'b0;
      endcase
   endfunction : padExp

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence: reset, register map, random events, then duration timing.
   initial begin
      {reset_n, rateFast, motionEventOne, dataReady, padOneSelect, padTwoSelect} = '0;
      {xSample, ySample, zSample} = '0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      for (int a = 8'h34; a <= 8'h38; a++) begin
         rd(8'(a), d);
         cmp8("reset value", 8'h00, d);
      end
      host_i.writeReg(DUR_ADDR, 8'hA5);
      rd(DUR_ADDR, d);
      cmp8("duration", 8'hA5, d);
      host_i.writeReg(THS_ADDR, 8'hDA);
      rd(THS_ADDR, d);
      cmp8("threshold", 8'hDA, d);
      host_i.writeReg(SRC_ADDR, 8'h7F);
      rd(SRC_ADDR, d);
      cmp8("source write", 8'h00, d);
      // Random configurations; the first four use samples that raise x high, y low, z high.
      for (int i = 0; i < 8; i++) begin
         quiet();
         c = 8'($random(seed));
         t = $random(seed) & 127;
         rateFast <= 1'($random(seed));
         if (i < 4) begin
            {xSample, ySample, zSample} <= {8'h40, 8'hFE, 8'h80};
            t = 16;
            c = {i[0], c[6], c[5:0] & 6'h26};
         end else begin
            xSample <= 8'($random(seed));
            ySample <= 8'($random(seed));
            zSample <= 8'($random(seed));
         end
         host_i.writeReg(THS_ADDR, 8'(t));
         host_i.writeReg(DUR_ADDR, 8'($random(seed) & 3));
         host_i.writeReg(CFG_ADDR, c);
         e = expSrc(c, 7'(t), xSample, ySample, zSample);
         repeat (90) @(posedge clk);
         motionEventOne <= 1'($random(seed));
         dataReady      <= 1'($random(seed));
         padOneSelect   <= i[2:0];
         padTwoSelect   <= ~i[2:0];
         @(posedge clk);
         @(negedge clk);
         cmp8("event", {7'h00, e[6]}, {7'h00, motionEventTwo_q});
         cmp8("pad one", {7'h00, padExp(i[2:0], motionEventOne, e[6], dataReady)},
              {7'h00, padOne_q});
         cmp8("pad two", {7'h00, padExp(~i[2:0], motionEventOne, e[6], dataReady)},
              {7'h00, padTwo_q});
         // A latched source is kept, but with the enables off no tick can reload it at the read.
         if (c[6]) begin
            host_i.writeReg(CFG_ADDR, c & 8'hC0);
         end
         rd(SRC_ADDR, d);
         cmp8("source", e, d);
         if (c[6]) begin
            cmp8("cleared", 8'h00, {7'h00, motionEventTwo_q});
         end
      end
      // Duration timing at each rate, with reset and decrement modes of the counter.
      for (int m = 0; m < 2; m++) begin
         quiet();
         t = m ? FAST : SLOW;
         rateFast <= m[0];
         {xSample, ySample, zSample} <= {8'h20, 8'h00, 8'h00};
         host_i.writeReg(THS_ADDR, {m[0], 7'h10});
         host_i.writeReg(DUR_ADDR, 8'h03);
         host_i.writeReg(CFG_ADDR, 8'h42);
         waitRise(n);
         rd(SRC_ADDR, d);
         cmp8("latched source", 8'h42, d);
         waitRise(n);
         cmpN("tick spacing", t, n);
         rd(SRC_ADDR, d);
         @(posedge clk);
         xSample <= 8'h00;
         while (cyc < lastRise + t + t / 2) @(posedge clk);
         xSample <= 8'h20;
         waitRise(n);
         cmpN("refire", m ? 2 * t : 5 * t, n);
      end
      stop_test();
   end
endmodule : testbench
